// File: src/codec_channel_rate_detect_cfg.sv
// Configuration bank for channel limits, rate converter and headset probe.
// Assumes a byte-wide control port already resolved to the correct page
// and one 25 MHz device clock with a synchronous active-low reset.
`timescale 1ns/100ps
`include "codec_cfg_defines.svh"

// Overview of operation
// - With the record force bit clear the record limit follows the default selector, else the custom mask.
// - The record custom mask sits in bits 6-3, bit 3 for channel four down to bit 0 for channel one.
// - With the playback force bit clear the playback limit follows its default selector, else its mask.
// - The playback custom mask sits in bits 6-3, resets to zero, bit 3 channel four to bit 0 channel one.
// - Bit 7 of the enable register switches the sample rate converter on when set.
// - Bit 6 of the enable register turns automatic rate detection off when set.
// - With the main rate manual bit clear the main rate is inferred, else it follows the port choice.
// - The port choice bit picks the primary serial port when 0 and the secondary when 1.
// - The ratio numerator code 0 infers m, codes 1-4 and 6 give m directly, 5 and 7 are reserved.
// - The ratio denominator code 0 infers n, codes 1-4 and 6 give n directly, 5 and 7 are reserved.
// - The probe rate field picks 0.5, 1, 7.5 or 15 Hz probe pulses.
// - The probe high time bit picks a 4 ms or 32 ms high time.
// - The tick field picks a 1, 2 or 4 ms detect tick; code 3 is reserved.
// - The enable register resets to zero, leaving the converter off and detection automatic.
module codec_channel_rate_detect_cfg
#(
    parameter int PERIOD_0_CYC = `PROBE_PERIOD_0_US * `CLK_MHZ,
    parameter int PERIOD_1_CYC = `PROBE_PERIOD_1_US * `CLK_MHZ,
    parameter int PERIOD_2_CYC = `PROBE_PERIOD_2_US * `CLK_MHZ,
    parameter int PERIOD_3_CYC = `PROBE_PERIOD_3_US * `CLK_MHZ,
    parameter int HIGH_SHORT_CYC = `PROBE_HIGH_SHORT_US * `CLK_MHZ,
    parameter int HIGH_LONG_CYC = `PROBE_HIGH_LONG_US * `CLK_MHZ,
    parameter int TICK_1_CYC = `TICK_1MS_US * `CLK_MHZ,
    parameter int TICK_2_CYC = `TICK_2MS_US * `CLK_MHZ,
    parameter int TICK_4_CYC = `TICK_4MS_US * `CLK_MHZ
)
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [3:0] record_default_limit_selector_in,
    input wire logic [3:0] playback_default_limit_selector_in,
    input wire logic primary_serial_port_rate_in,
    input wire logic secondary_serial_port_rate_in,
    input wire logic inferred_main_rate_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    output logic [3:0] record_channel_enable_out,
    output logic [3:0] playback_channel_enable_out,
    output logic rate_converter_on_out,
    output logic rate_autodetect_on_out,
    output logic [1:0] main_rate_source_out,
    output logic main_rate_out,
    output logic [2:0] ratio_m_out,
    output logic ratio_m_infer_out,
    output logic [2:0] ratio_n_out,
    output logic ratio_n_infer_out,
    output logic ratio_reserved_out,
    output logic headset_probe_pulse_out,
    output logic headphone_detect_tick_out
);

    logic [7:0] record_channel_limit_cfg_q;
    logic [7:0] playback_channel_limit_cfg_q;
    logic [7:0] rate_converter_enable_cfg_q;
    logic [7:0] rate_converter_ratio_cfg_q;
    logic [7:0] headset_probe_timing_cfg_q;
    logic [7:0] rdata_d;
    logic record_force_custom_limit;
    logic playback_force_custom_limit;
    logic [3:0] record_custom_channel_mask;
    logic [3:0] playback_custom_channel_mask;
    logic main_rate_manual;
    logic main_rate_port_choice;
    logic [2:0] m_value;
    logic [2:0] n_value;
    logic m_infer;
    logic n_infer;
    logic m_reserved;
    logic n_reserved;
    logic probe_pulse;
    logic detect_tick;
    codec_cfg_pkg::limit_source_t record_source;
    codec_cfg_pkg::limit_source_t playback_source;
    codec_cfg_pkg::main_rate_source_t main_source;

    // Only writable fields are stored; reserved bits never hold a one.
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            record_channel_limit_cfg_q <= `RST_RECORD_LIMIT;
            playback_channel_limit_cfg_q <= `RST_PLAYBACK_LIMIT;
            rate_converter_enable_cfg_q <= `RST_RATE_ENABLE;
            rate_converter_ratio_cfg_q <= `RST_RATE_RATIO;
            headset_probe_timing_cfg_q <= `RST_PROBE_TIMING;
        end
        else if (reg_wr_in)
        begin
            unique case (reg_addr_in)
                `OFS_RECORD_LIMIT:
                    record_channel_limit_cfg_q <=
                        reg_wdata_in & `MASK_LIMIT;
                `OFS_PLAYBACK_LIMIT:
                    playback_channel_limit_cfg_q <=
                        reg_wdata_in & `MASK_LIMIT;
                `OFS_RATE_ENABLE:
                    rate_converter_enable_cfg_q <=
                        reg_wdata_in & `MASK_RATE_ENABLE;
                `OFS_RATE_RATIO:
                    rate_converter_ratio_cfg_q <=
                        reg_wdata_in & `MASK_RATE_RATIO;
                `OFS_PROBE_TIMING:
                    headset_probe_timing_cfg_q <=
                        reg_wdata_in & `MASK_PROBE_TIMING;
                default:
                    ;
            endcase
        end
    end

    // Unmapped offsets read as zero; the page register belongs elsewhere.
    always_comb
    begin
        unique case (reg_addr_in)
            `OFS_RECORD_LIMIT: rdata_d = record_channel_limit_cfg_q;
            `OFS_PLAYBACK_LIMIT: rdata_d = playback_channel_limit_cfg_q;
            `OFS_RATE_ENABLE: rdata_d = rate_converter_enable_cfg_q;
            `OFS_RATE_RATIO: rdata_d = rate_converter_ratio_cfg_q;
            `OFS_PROBE_TIMING: rdata_d = headset_probe_timing_cfg_q;
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            reg_rdata_out <= 8'h00;
            reg_rvalid_out <= 1'b0;
        end
        else
        begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in)
            begin
                reg_rdata_out <= rdata_d;
            end
        end
    end

    assign record_force_custom_limit =
        record_channel_limit_cfg_q[`BIT_FORCE];
    assign record_custom_channel_mask =
        record_channel_limit_cfg_q[`MSB_CHMASK:`LSB_CHMASK];
    assign playback_force_custom_limit =
        playback_channel_limit_cfg_q[`BIT_FORCE];
    assign playback_custom_channel_mask =
        playback_channel_limit_cfg_q[`MSB_CHMASK:`LSB_CHMASK];
    assign main_rate_manual = rate_converter_ratio_cfg_q[`BIT_MAIN_MANUAL];
    assign main_rate_port_choice =
        rate_converter_ratio_cfg_q[`BIT_PORT_CHOICE];

    always_comb
    begin
        record_source = record_force_custom_limit ?
            codec_cfg_pkg::LIMIT_CUSTOM : codec_cfg_pkg::LIMIT_DEFAULT;
        playback_source = playback_force_custom_limit ?
            codec_cfg_pkg::LIMIT_CUSTOM : codec_cfg_pkg::LIMIT_DEFAULT;
        if (!main_rate_manual)
        begin
            main_source = codec_cfg_pkg::MAIN_AUTO;
        end
        else if (main_rate_port_choice)
        begin
            main_source = codec_cfg_pkg::MAIN_SECONDARY;
        end
        else
        begin
            main_source = codec_cfg_pkg::MAIN_PRIMARY;
        end
    end

    ratio_code_decode u_ratio_m
    (
        .code_in(rate_converter_ratio_cfg_q[`MSB_RATIO_M:`LSB_RATIO_M]),
        .value_out(m_value),
        .infer_out(m_infer),
        .reserved_out(m_reserved)
    );

    ratio_code_decode u_ratio_n
    (
        .code_in(rate_converter_ratio_cfg_q[`MSB_RATIO_N:`LSB_RATIO_N]),
        .value_out(n_value),
        .infer_out(n_infer),
        .reserved_out(n_reserved)
    );

    probe_timer
    #(
        .PERIOD_0_CYC(PERIOD_0_CYC),
        .PERIOD_1_CYC(PERIOD_1_CYC),
        .PERIOD_2_CYC(PERIOD_2_CYC),
        .PERIOD_3_CYC(PERIOD_3_CYC),
        .HIGH_SHORT_CYC(HIGH_SHORT_CYC),
        .HIGH_LONG_CYC(HIGH_LONG_CYC),
        .TICK_1_CYC(TICK_1_CYC),
        .TICK_2_CYC(TICK_2_CYC),
        .TICK_4_CYC(TICK_4_CYC)
    )
    u_probe_timer
    (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .rate_sel_in(headset_probe_timing_cfg_q[`MSB_PROBE_RATE:
            `LSB_PROBE_RATE]),
        .long_high_in(headset_probe_timing_cfg_q[`BIT_PROBE_HIGH]),
        .tick_sel_in(headset_probe_timing_cfg_q[`MSB_TICK_SEL:
            `LSB_TICK_SEL]),
        .probe_pulse_out(probe_pulse),
        .tick_out(detect_tick)
    );

    // Channel limits; outputs follow a write one clock after the register.
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            record_channel_enable_out <= 4'h0;
            playback_channel_enable_out <= 4'h0;
        end
        else
        begin
            record_channel_enable_out <=
                (record_source == codec_cfg_pkg::LIMIT_CUSTOM) ?
                record_custom_channel_mask :
                record_default_limit_selector_in;
            playback_channel_enable_out <=
                (playback_source == codec_cfg_pkg::LIMIT_CUSTOM) ?
                playback_custom_channel_mask :
                playback_default_limit_selector_in;
        end
    end

    // Rate converter controls.
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            rate_converter_on_out <= 1'b0;
            rate_autodetect_on_out <= 1'b1;
            main_rate_source_out <= 2'h0;
            main_rate_out <= 1'b0;
        end
        else
        begin
            rate_converter_on_out <=
                rate_converter_enable_cfg_q[`BIT_CONV_ON];
            rate_autodetect_on_out <=
                !rate_converter_enable_cfg_q[`BIT_AUTODET_OFF];
            main_rate_source_out <= main_source;
            unique case (main_source)
                codec_cfg_pkg::MAIN_PRIMARY:
                    main_rate_out <= primary_serial_port_rate_in;
                codec_cfg_pkg::MAIN_SECONDARY:
                    main_rate_out <= secondary_serial_port_rate_in;
                default:
                    main_rate_out <= inferred_main_rate_in;
            endcase
        end
    end

    // Ratio fields and the probe timer outputs.
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            ratio_m_out <= 3'h0;
            ratio_m_infer_out <= 1'b1;
            ratio_n_out <= 3'h0;
            ratio_n_infer_out <= 1'b1;
            ratio_reserved_out <= 1'b0;
            headset_probe_pulse_out <= 1'b0;
            headphone_detect_tick_out <= 1'b0;
        end
        else
        begin
            ratio_m_out <= m_value;
            ratio_m_infer_out <= m_infer;
            ratio_n_out <= n_value;
            ratio_n_infer_out <= n_infer;
            ratio_reserved_out <= m_reserved | n_reserved;
            headset_probe_pulse_out <= probe_pulse;
            headphone_detect_tick_out <= detect_tick;
        end
    end

endmodule : codec_channel_rate_detect_cfg

// File: src/codec_cfg_defines.svh
// Offsets, field positions, reset values and timing figures for the bank.
// Assumes inclusion by bare name from the design files.
`ifndef CODEC_CFG_DEFINES_SVH
`define CODEC_CFG_DEFINES_SVH

`define OFS_RECORD_LIMIT 8'h0E
`define OFS_PLAYBACK_LIMIT 8'h0F
`define OFS_RATE_ENABLE 8'h17
`define OFS_RATE_RATIO 8'h18
`define OFS_PROBE_TIMING 8'h19
`define OFS_PAGE_SELECT 8'h00

`define RST_RECORD_LIMIT 8'h00
`define RST_PLAYBACK_LIMIT 8'h00
`define RST_RATE_ENABLE 8'h00
`define RST_RATE_RATIO 8'h00
`define RST_PROBE_TIMING 8'h00

`define MASK_LIMIT 8'hF8
`define MASK_RATE_ENABLE 8'hC0
`define MASK_RATE_RATIO 8'hFF
`define MASK_PROBE_TIMING 8'hE6

`define BIT_FORCE 7
`define MSB_CHMASK 6
`define LSB_CHMASK 3
`define BIT_CONV_ON 7
`define BIT_AUTODET_OFF 6
`define BIT_MAIN_MANUAL 7
`define BIT_PORT_CHOICE 6
`define MSB_RATIO_M 5
`define LSB_RATIO_M 3
`define MSB_RATIO_N 2
`define LSB_RATIO_N 0
`define MSB_PROBE_RATE 7
`define LSB_PROBE_RATE 6
`define BIT_PROBE_HIGH 5
`define MSB_TICK_SEL 2
`define LSB_TICK_SEL 1

`define RATIO_AUTO 3'h0
`define RATIO_MAX_DIRECT 3'h4
`define RATIO_SIX 3'h6

// Probe and tick times in microseconds; clock is 25 MHz.
`define CLK_MHZ 25
`define PROBE_HIGH_SHORT_US 4000
`define PROBE_HIGH_LONG_US 32000
`define TICK_1MS_US 1000
`define TICK_2MS_US 2000
`define TICK_4MS_US 4000
// Probe periods in microseconds: 0.5 Hz, 1 Hz, 7.5 Hz, 15 Hz.
`define PROBE_PERIOD_0_US 2000000
`define PROBE_PERIOD_1_US 1000000
`define PROBE_PERIOD_2_US 133333
`define PROBE_PERIOD_3_US 66666

`endif

// File: src/codec_cfg_pkg.sv
// Types shared by the configuration bank and its helpers.
// Assumes the defines header is compiled alongside.
package codec_cfg_pkg;

    typedef enum logic [1:0]
    {
        LIMIT_DEFAULT = 2'b00,
        LIMIT_CUSTOM = 2'b01
    } limit_source_t;

    typedef enum logic [1:0]
    {
        MAIN_AUTO = 2'b00,
        MAIN_PRIMARY = 2'b01,
        MAIN_SECONDARY = 2'b10
    } main_rate_source_t;

endpackage : codec_cfg_pkg

// File: src/ratio_code_decode.sv
// Decodes one m:n ratio field into a value, an infer flag and a reserved flag.
// Assumes a registered field from the same clock domain.
`timescale 1ns/100ps
`include "codec_cfg_defines.svh"

module ratio_code_decode
(
    input wire logic [2:0] code_in,
    output logic [2:0] value_out,
    output logic infer_out,
    output logic reserved_out
);

    always_comb
    begin
        infer_out = (code_in == `RATIO_AUTO);
        reserved_out = 1'b0;
        value_out = 3'h0;
        if (code_in != `RATIO_AUTO && code_in <= `RATIO_MAX_DIRECT)
        begin
            value_out = code_in;
        end
        else if (code_in == `RATIO_SIX)
        begin
            value_out = code_in;
        end
        else if (code_in != `RATIO_AUTO)
        begin
            // Reserved codes fall back to inferring so the converter stays sane.
            reserved_out = 1'b1;
            infer_out = 1'b1;
        end
    end

endmodule : ratio_code_decode

// File: src/probe_timer.sv
// Produces the headset probe pulse train and the headphone detect tick.
// Assumes clk_in at 25 MHz and a synchronous active-low reset.
`timescale 1ns/100ps
`include "codec_cfg_defines.svh"

module probe_timer
#(
    parameter int PERIOD_0_CYC = `PROBE_PERIOD_0_US * `CLK_MHZ,
    parameter int PERIOD_1_CYC = `PROBE_PERIOD_1_US * `CLK_MHZ,
    parameter int PERIOD_2_CYC = `PROBE_PERIOD_2_US * `CLK_MHZ,
    parameter int PERIOD_3_CYC = `PROBE_PERIOD_3_US * `CLK_MHZ,
    parameter int HIGH_SHORT_CYC = `PROBE_HIGH_SHORT_US * `CLK_MHZ,
    parameter int HIGH_LONG_CYC = `PROBE_HIGH_LONG_US * `CLK_MHZ,
    parameter int TICK_1_CYC = `TICK_1MS_US * `CLK_MHZ,
    parameter int TICK_2_CYC = `TICK_2MS_US * `CLK_MHZ,
    parameter int TICK_4_CYC = `TICK_4MS_US * `CLK_MHZ
)
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [1:0] rate_sel_in,
    input wire logic long_high_in,
    input wire logic [1:0] tick_sel_in,
    output logic probe_pulse_out,
    output logic tick_out
);

    logic [31:0] period_cnt_q;
    logic [31:0] tick_cnt_q;
    logic [31:0] period_len;
    logic [31:0] high_len;
    logic [31:0] tick_len;

    always_comb
    begin
        unique case (rate_sel_in)
            2'h0: period_len = 32'(PERIOD_0_CYC);
            2'h1: period_len = 32'(PERIOD_1_CYC);
            2'h2: period_len = 32'(PERIOD_2_CYC);
            2'h3: period_len = 32'(PERIOD_3_CYC);
        endcase
        high_len = long_high_in ? 32'(HIGH_LONG_CYC) : 32'(HIGH_SHORT_CYC);
        // The reserved tick code is held at the slowest setting.
        unique case (tick_sel_in)
            2'h0: tick_len = 32'(TICK_1_CYC);
            2'h1: tick_len = 32'(TICK_2_CYC);
            default: tick_len = 32'(TICK_4_CYC);
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            period_cnt_q <= 32'h0;
            probe_pulse_out <= 1'b0;
        end
        else
        begin
            if (period_cnt_q + 32'h1 >= period_len)
            begin
                period_cnt_q <= 32'h0;
            end
            else
            begin
                period_cnt_q <= period_cnt_q + 32'h1;
            end
            probe_pulse_out <= (period_cnt_q < high_len);
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            tick_cnt_q <= 32'h0;
            tick_out <= 1'b0;
        end
        else if (tick_cnt_q + 32'h1 >= tick_len)
        begin
            tick_cnt_q <= 32'h0;
            tick_out <= 1'b1;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
            tick_out <= 1'b0;
        end
    end

endmodule : probe_timer

// File: tb/codec_channel_rate_detect_cfg_checker.sv
// Concurrent checks on the configuration bank ports.
// Assumes binding to the bank top, one clock and an active-low reset.
`timescale 1ns/100ps
module cfg_bank_checker
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [3:0] record_default_limit_selector_in,
    input wire logic reg_rvalid_out,
    input wire logic [3:0] record_channel_enable_out,
    input wire logic [3:0] playback_channel_enable_out,
    input wire logic rate_converter_on_out,
    input wire logic rate_autodetect_on_out,
    input wire logic [1:0] main_rate_source_out,
    input wire logic [2:0] ratio_m_out,
    input wire logic ratio_m_infer_out,
    input wire logic ratio_reserved_out,
    input wire logic headphone_detect_tick_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);

    function automatic logic bad(input logic [2:0] c);
        return c == 3'h5 || c == 3'h7;
    endfunction : bad

    wire wr_rec = reg_wr_in && reg_addr_in == 8'h0E;
    wire wr_pla = reg_wr_in && reg_addr_in == 8'h0F;
    wire wr_en = reg_wr_in && reg_addr_in == 8'h17;
    wire wr_rat = reg_wr_in && reg_addr_in == 8'h18;
    wire m_direct = !bad(reg_wdata_in[5:3]) && reg_wdata_in[5:3] != 3'h0;
    wire rat_bad = bad(reg_wdata_in[5:3]) || bad(reg_wdata_in[2:0]);

    property p_rvalid;
        reg_rd_in |=> reg_rvalid_out;
    endproperty
    property p_rvalid_cause;
        reg_rvalid_out |-> $past(reg_rd_in);
    endproperty
    property p_rec_custom;
        wr_rec && reg_wdata_in[7] |->
            ##2 record_channel_enable_out == $past(reg_wdata_in[6:3], 2);
    endproperty
    property p_rec_default;
        wr_rec && !reg_wdata_in[7] ##1 !wr_rec |=>
        record_channel_enable_out == $past(record_default_limit_selector_in);
    endproperty
    property p_pla_custom;
        wr_pla && reg_wdata_in[7] |->
            ##2 playback_channel_enable_out == $past(reg_wdata_in[6:3], 2);
    endproperty
    property p_conv;
        wr_en |-> ##2 rate_converter_on_out == $past(reg_wdata_in[7], 2);
    endproperty
    property p_autodet;
        wr_en |-> ##2 rate_autodetect_on_out != $past(reg_wdata_in[6], 2);
    endproperty
    property p_main_src;
        wr_rat |-> ##2 main_rate_source_out == (!$past(reg_wdata_in[7], 2) ?
            2'h0 : ($past(reg_wdata_in[6], 2) ? 2'h2 : 2'h1));
    endproperty
    property p_ratio_m;
        wr_rat && m_direct |->
            ##2 ratio_m_out == $past(reg_wdata_in[5:3], 2)
            && !ratio_m_infer_out;
    endproperty
    property p_reserved;
        wr_rat |-> ##2 ratio_reserved_out == $past(rat_bad, 2);
    endproperty
    property p_reset;
        disable iff (1'b0)
        !rst_b_in |=> rate_autodetect_on_out && !rate_converter_on_out
            && ratio_m_infer_out;
    endproperty
    property p_tick;
        headphone_detect_tick_out |=> !headphone_detect_tick_out;
    endproperty

    a_rvalid: assert property (p_rvalid)
        else $error("read strobe not answered next cycle");
    a_rvalid_cause: assert property (p_rvalid_cause)
        else $error("read valid without a read");
    a_rec_custom: assert property (p_rec_custom)
        else $error("record enables differ from custom mask");
    a_rec_default: assert property (p_rec_default)
        else $error("record enables differ from default selector");
    a_pla_custom: assert property (p_pla_custom)
        else $error("playback enables differ from custom mask");
    a_conv: assert property (p_conv)
        else $error("converter enable differs from written bit");
    a_autodet: assert property (p_autodet)
        else $error("autodetect flag not inverse of written bit");
    a_main_src: assert property (p_main_src)
        else $error("main rate source wrong");
    a_ratio_m: assert property (p_ratio_m)
        else $error("ratio numerator wrong");
    a_reserved: assert property (p_reserved)
        else $error("reserved ratio flag wrong");
    a_reset: assert property (p_reset)
        else $error("converter outputs wrong after reset");
    a_tick: assert property (p_tick)
        else $error("detect tick longer than one cycle");

    c_read: cover property (reg_rd_in);
    c_conv_on: cover property (wr_en && reg_wdata_in[7]);
    c_tick: cover property (headphone_detect_tick_out);
endmodule : cfg_bank_checker

bind codec_channel_rate_detect_cfg cfg_bank_checker chk_u
(
    .clk_in, .rst_b_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in,
    .record_default_limit_selector_in, .reg_rvalid_out,
    .record_channel_enable_out, .playback_channel_enable_out,
    .rate_converter_on_out, .rate_autodetect_on_out, .main_rate_source_out,
    .ratio_m_out, .ratio_m_infer_out, .ratio_reserved_out,
    .headphone_detect_tick_out
);

// File: tb/codec_channel_rate_detect_cfg_bench.sv
// Self-checking bench for the configuration bank.
// Assumes shortened probe and tick counts set at the instance below.
`timescale 1ns/100ps
module codec_channel_rate_detect_cfg_bench;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic [3:0] record_default_limit_selector_in = 4'hA;
    logic [3:0] playback_default_limit_selector_in = 4'h5;
    logic primary_serial_port_rate_in = 1'b1;
    logic secondary_serial_port_rate_in = 1'b0;
    logic inferred_main_rate_in = 1'b0;
    logic [7:0] reg_rdata_out;
    logic reg_rvalid_out;
    logic [3:0] record_channel_enable_out;
    logic [3:0] playback_channel_enable_out;
    logic rate_converter_on_out;
    logic rate_autodetect_on_out;
    logic [1:0] main_rate_source_out;
    logic main_rate_out;
    logic [2:0] ratio_m_out;
    logic ratio_m_infer_out;
    logic [2:0] ratio_n_out;
    logic ratio_n_infer_out;
    logic ratio_reserved_out;
    logic headset_probe_pulse_out;
    logic headphone_detect_tick_out;
    int miscompares = 0;
    int comparisons = 0;
    // Rows hold offset, written byte and expected read-back.
    logic [23:0] rows [0:6] = '{24'h0EFFF8, 24'h0FFFF8, 24'h17FFC0,
        24'h18FFFF, 24'h19FFE6, 24'h20FF00, 24'h00FF00};

    codec_channel_rate_detect_cfg #(.PERIOD_0_CYC(40), .PERIOD_1_CYC(20),
        .PERIOD_2_CYC(8), .PERIOD_3_CYC(4), .HIGH_SHORT_CYC(2),
        .HIGH_LONG_CYC(6), .TICK_1_CYC(3), .TICK_2_CYC(5), .TICK_4_CYC(7))
    dut_u (.clk_in, .rst_b_in, .reg_wr_in, .reg_rd_in, .reg_addr_in,
        .reg_wdata_in, .record_default_limit_selector_in,
        .playback_default_limit_selector_in, .primary_serial_port_rate_in,
        .secondary_serial_port_rate_in, .inferred_main_rate_in,
        .reg_rdata_out, .reg_rvalid_out, .record_channel_enable_out,
        .playback_channel_enable_out, .rate_converter_on_out,
        .rate_autodetect_on_out, .main_rate_source_out, .main_rate_out,
        .ratio_m_out, .ratio_m_infer_out, .ratio_n_out, .ratio_n_infer_out,
        .ratio_reserved_out, .headset_probe_pulse_out,
        .headphone_detect_tick_out);

    initial
    begin
        forever #20 clk_in = ~clk_in;
    end

    task automatic close_out;
        if (miscompares == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Every task starts and ends just after a rising edge.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        reg_wr_in = 1'b1;
        reg_addr_in = a;
        reg_wdata_in = d;
        @(posedge clk_in);
        #1;
        reg_wr_in = 1'b0;
        @(posedge clk_in);
        #1;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        reg_rd_in = 1'b1;
        reg_addr_in = a;
        @(posedge clk_in);
        #1;
        reg_rd_in = 1'b0;
        check(reg_rvalid_out, 1);
        check(reg_rdata_out, exp);
        @(posedge clk_in);
        #1;
    endtask : rd_reg

    // A window of 840 cycles is a whole number of every period in use.
    task automatic measure(input logic [7:0] cfg, input int pe, input int te);
        int p;
        int t;
        p = 0;
        t = 0;
        wr_reg(8'h19, cfg);
        repeat (50) @(posedge clk_in);
        repeat (840)
        begin
            @(posedge clk_in);
            #1;
            p += headset_probe_pulse_out;
            t += headphone_detect_tick_out;
        end
        check(p[15:0], pe[15:0]);
        check(t[15:0], te[15:0]);
    endtask : measure

    function automatic logic [2:0] vexp(input logic [2:0] c);
        return (c == 3'h0 || c == 3'h5 || c == 3'h7) ? 3'h0 : c;
    endfunction : vexp

    initial
    begin
        #1000000;
        miscompares++;
        close_out();
    end

    initial
    begin
        repeat (5) @(posedge clk_in);
        #1;
        rst_b_in = 1'b1;
        check({rate_autodetect_on_out, rate_converter_on_out}, 2'h2);
        for (int i = 0; i < 5; i++)
            rd_reg(rows[i][23:16], 8'h00);
        for (int i = 0; i < 7; i++)
            wr_reg(rows[i][23:16], rows[i][15:8]);
        for (int i = 0; i < 7; i++)
            rd_reg(rows[i][23:16], rows[i][7:0]);
        record_default_limit_selector_in = 4'h3;
        wr_reg(8'h0E, 8'h00);
        check(record_channel_enable_out, 4'h3);
        wr_reg(8'h0E, 8'hB0);
        check(record_channel_enable_out, 4'h6);
        playback_default_limit_selector_in = 4'hC;
        wr_reg(8'h0F, 8'h00);
        check(playback_channel_enable_out, 4'hC);
        wr_reg(8'h0F, 8'hC8);
        check(playback_channel_enable_out, 4'h9);
        wr_reg(8'h17, 8'h80);
        check({rate_converter_on_out, rate_autodetect_on_out}, 2'h3);
        wr_reg(8'h17, 8'h40);
        check({rate_converter_on_out, rate_autodetect_on_out}, 2'h0);
        reg_rd_in = 1'b1;
        reg_wr_in = 1'b1;
        reg_wdata_in = 8'hC0;
        @(posedge clk_in);
        #1;
        reg_rd_in = 1'b0;
        reg_wr_in = 1'b0;
        check(reg_rdata_out, 8'h40);
        @(posedge clk_in);
        #1;
        rd_reg(8'h17, 8'hC0);
        for (int c = 0; c < 8; c++)
        begin
            wr_reg(8'h18, {2'h0, c[2:0], 3'h7 - c[2:0]});
            check(ratio_m_out, vexp(c[2:0]));
            check(ratio_m_infer_out, vexp(c[2:0]) == 3'h0);
            check(ratio_n_out, vexp(3'h7 - c[2:0]));
            check(ratio_n_infer_out, vexp(3'h7 - c[2:0]) == 3'h0);
            check(ratio_reserved_out,
                c == 0 || c == 2 || c == 5 || c == 7);
        end
        for (int k = 0; k < 3; k++)
        begin
            // Only the source that should be picked is high.
            inferred_main_rate_in = k == 0;
            primary_serial_port_rate_in = k == 1;
            secondary_serial_port_rate_in = k == 2;
            wr_reg(8'h18, k == 0 ? 8'h00 : (k == 1 ? 8'h80 : 8'hC0));
            check(main_rate_source_out, k[1:0]);
            check(main_rate_out, 1'b1);
        end
        measure(8'h00, 42, 280);
        measure(8'h62, 252, 168);
        measure(8'h84, 210, 120);
        measure(8'hE6, 840, 120);
        rst_b_in = 1'b0;
        repeat (5) @(posedge clk_in);
        #1;
        rst_b_in = 1'b1;
        check(rate_autodetect_on_out, 1'b1);
        rd_reg(8'h17, 8'h00);
        close_out();
    end
endmodule : codec_channel_rate_detect_cfg_bench
